// [logic/pin_function_mux.sv]
// Purpose: Per-pin function multiplexer for Port B pins 5,6,7,10,11 and Port C 0..2.
// Assumes: Selections and peripheral signals are on mclk; pads are asynchronous.
// Notes:   All outputs are registered, so a change shows one edge later.
//          Pad levels reach peripherals three edges after the pin moves.
//          Unused selection codes leave the pin undriven and unrouted.
// Functional notes
// - Each GPIO pin has its own direction.
// - Reset leaves every pin in GPIO.
// - Alternates follow only the integration selection, except pin 6 clock, pin 5 clock (yields to pin 6) and pin 6 receive (yields to pin 7 single-wire).
// - Pin 6 clock needs selection and mode.
// - Analog pin 0 feeds ADC and comparator.
// - Fault alternate drives PWM fault input.
// - Single-wire makes transmit pin bidirectional.
// - Comparator A and B drive their pins.
`timescale 1ns/100ps
module pin_function_mux
  import pin_mux_pkg::*;
(
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                nrst,
  // Pads
  input  wire logic [NUM_PINS-1:0] pad_in,
  output logic      [NUM_PINS-1:0] pad_out,
  output logic      [NUM_PINS-1:0] pad_oe,
  // Selections from system_integration_unit
  input  wire logic [SEL_W-1:0]    sel_b5,
  input  wire logic [SEL_W-1:0]    sel_b6,
  input  wire logic [SEL_W-1:0]    sel_b7,
  input  wire logic [SEL_W-1:0]    sel_b10,
  input  wire logic [SEL_W-1:0]    sel_b11,
  input  wire logic [SEL_W-1:0]    sel_c0,
  input  wire logic [SEL_W-1:0]    sel_c1,
  input  wire logic [SEL_W-1:0]    sel_c2,
  // Clock_synth_unit mode bit
  input  wire logic                osc_clock_source_select,
  // General-purpose port
  input  wire logic [NUM_PINS-1:0] gpio_data_out,
  input  wire logic [NUM_PINS-1:0] gpio_dir_out,
  output logic      [NUM_PINS-1:0] gpio_data_in,
  // Timer A channel 1
  input  wire logic                timer_a_channel1_out,
  input  wire logic                timer_a_channel1_oe,
  output logic                     timer_a_channel1_in,
  // PWM fault
  output logic                     pwm_fault_in_3,
  // Serial_port_0
  input  wire logic                serial0_transmit,
  input  wire logic                serial0_single_wire,
  input  wire logic                serial0_tx_drive,
  output logic                     serial0_receive,
  // I2C open-drain lines (drive low requests)
  input  wire logic                i2c_sda_drive_low,
  input  wire logic                i2c_scl_drive_low,
  output logic                     i2c_sda_in,
  output logic                     i2c_scl_in,
  // Comparators
  input  wire logic                comparator_a_out,
  input  wire logic                comparator_b_out,
  // External clock
  output logic                     external_clock_input,
  output logic                     external_clock_active,
  // Analog switch enables
  output logic                     adc_a_channel0,
  output logic                     comparator_a_input3,
  output logic                     adc_a_channel1,
  output logic                     adc_a_channel2
);

  // Synchronised pad levels, two edges behind the pins
  logic [NUM_PINS-1:0] pin_s;

  // Pads are asynchronous, so every pad level is synchronised first
  pin_sync #(
    .WIDTH    (NUM_PINS)
  ) u_sync (
    .mclk     (mclk),
    .nrst     (nrst),
    .async_in (pad_in),
    .sync_out (pin_s)
  );

  // Code zero is GPIO on every pin, so the reset selection needs no decode
  // Per-pin general-purpose flags
  wire b5_gpio  = (sel_b5 == SEL_GPIO);
  wire b6_gpio  = (sel_b6 == SEL_GPIO);
  wire b7_gpio  = (sel_b7 == SEL_GPIO);
  wire b10_gpio = (sel_b10 == SEL_GPIO);
  wire b11_gpio = (sel_b11 == SEL_GPIO);
  wire c0_gpio  = (sel_c0 == SEL_GPIO);
  wire c1_gpio  = (sel_c1 == SEL_GPIO);
  wire c2_gpio  = (sel_c2 == SEL_GPIO);
  wire [NUM_PINS-1:0] gpio_sel = {c2_gpio, c1_gpio, c0_gpio, b11_gpio,
                                  b10_gpio, b7_gpio, b6_gpio, b5_gpio};

  wire b5_timer  = (sel_b5 == SEL_B5_TIMER);
  wire b5_fault  = (sel_b5 == SEL_B5_FAULT);
  wire b5_external_clock_input  = (sel_b5 == SEL_B5_EXTERNAL_CLOCK_INPUT);
  wire b6_rx     = (sel_b6 == SEL_B6_RECEIVE);
  wire b6_sda    = (sel_b6 == SEL_B6_SDA);
  wire b7_tx     = (sel_b7 == SEL_B7_TRANSMIT);
  wire b7_scl    = (sel_b7 == SEL_B7_SCL);
  wire b10_cmp   = (sel_b10 == SEL_CMP_OUT);
  wire b11_cmp   = (sel_b11 == SEL_CMP_OUT);
  wire c0_analog = (sel_c0 == SEL_ANALOG);
  wire c1_analog = (sel_c1 == SEL_ANALOG);
  wire c2_analog = (sel_c2 == SEL_ANALOG);

  // pin 6 clock also needs the oscillator mode bit
  wire b6_external_clock_input = (sel_b6 == SEL_B6_EXTERNAL_CLOCK_INPUT) &&
                  (osc_clock_source_select == OSC_CLOCK_SOURCE_SELECT_EXTERNAL);

  // Without single-wire the pin drives even between frames
  // single-wire lets the serial port turn the pin round
  wire tx_oe = serial0_single_wire ? serial0_tx_drive : 1'b1;

  // pin 5 drive from the selected function
  wire b5_out = b5_gpio ? gpio_data_out[PIN_B5] : timer_a_channel1_out;
  wire b5_oe  = b5_gpio ? gpio_dir_out[PIN_B5] : (b5_timer & timer_a_channel1_oe);

  // pin 6 drive; I2C only ever pulls low
  wire b6_out = b6_gpio & gpio_data_out[PIN_B6];
  wire b6_oe  = b6_gpio ? gpio_dir_out[PIN_B6] : (b6_sda & i2c_sda_drive_low);

  wire b7_out = b7_gpio ? gpio_data_out[PIN_B7] : (b7_tx & serial0_transmit);
  wire b7_oe  = b7_gpio ? gpio_dir_out[PIN_B7] :
                b7_tx   ? tx_oe : (b7_scl & i2c_scl_drive_low);

  // A selected comparator pin always drives; there is no tristate
  // comparator outputs on pins 10 and 11
  wire b10_out = b10_cmp ? comparator_a_out : gpio_data_out[PIN_B10];
  wire b10_oe  = b10_cmp | (b10_gpio & gpio_dir_out[PIN_B10]);
  wire b11_out = b11_cmp ? comparator_b_out : gpio_data_out[PIN_B11];
  wire b11_oe  = b11_cmp | (b11_gpio & gpio_dir_out[PIN_B11]);

  // Port C digital drive only in GPIO, by its own direction bit
  wire [2:0] c_out = gpio_data_out[PIN_C2:PIN_C0] & {c2_gpio, c1_gpio, c0_gpio};
  wire [2:0] c_oe  = gpio_dir_out[PIN_C2:PIN_C0] & {c2_gpio, c1_gpio, c0_gpio};

  // Reserved codes fall through to no drive at all
  // Assembled pad drive
  wire [NUM_PINS-1:0] out_d = {c_out, b11_out, b10_out, b7_out, b6_out, b5_out};
  wire [NUM_PINS-1:0] oe_d  = {c_oe, b11_oe, b10_oe, b7_oe, b6_oe, b5_oe};

  // peripheral inputs see the pin only when selected
  wire timer_d  = b5_timer ? pin_s[PIN_B5] : IDLE_TIMER_IN;
  // fault level reaches the PWM only via its alternate
  wire fault_d  = b5_fault ? pin_s[PIN_B5] : IDLE_FAULT;
  // One receive source only; B7 single-wire wins over B6 receive
  // single-wire receive comes back over the transmit pin
  wire rx_d     = (b7_tx && serial0_single_wire) ? pin_s[PIN_B7] :
                  b6_rx ? pin_s[PIN_B6] : IDLE_RECEIVE;
  wire sda_d    = b6_sda ? pin_s[PIN_B6] : IDLE_I2C;
  wire scl_d    = b7_scl ? pin_s[PIN_B7] : IDLE_I2C;
  // Pin clock is resampled on mclk, so it must stay well below mclk/2
  // pin 6 takes priority over pin 5 as clock source
  wire clk_d    = b6_external_clock_input ? pin_s[PIN_B6] :
                  b5_external_clock_input ? pin_s[PIN_B5] : IDLE_EXTERNAL_CLOCK_INPUT;
  wire clk_on_d = b6_external_clock_input | b5_external_clock_input;

  // Analog pins give no digital reading, avoiding a floating input
  wire [NUM_PINS-1:0] gin_d = pin_s & gpio_sel;

  // reset returns every pad to an undriven GPIO input
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pad_out <= RST_PIN_OUT;
      pad_oe  <= RST_PIN_OE;
    end else begin
      pad_out <= out_d;
      pad_oe  <= oe_d;
    end
  end

  // digital peripheral inputs held idle in reset
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      gpio_data_in        <= '0;
      timer_a_channel1_in <= IDLE_TIMER_IN;
      pwm_fault_in_3      <= IDLE_FAULT;
      serial0_receive     <= IDLE_RECEIVE;
    end else begin
      gpio_data_in        <= gin_d;
      timer_a_channel1_in <= timer_d;
      pwm_fault_in_3      <= fault_d;
      serial0_receive     <= rx_d;
    end
  end

  // I2C lines read released, no clock in reset
  // Idle I2C level is high, so no false start follows release
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      i2c_sda_in            <= IDLE_I2C;
      i2c_scl_in            <= IDLE_I2C;
      external_clock_input  <= IDLE_EXTERNAL_CLOCK_INPUT;
      external_clock_active <= 1'b0;
    end else begin
      i2c_sda_in            <= sda_d;
      i2c_scl_in            <= scl_d;
      external_clock_input  <= clk_d;
      external_clock_active <= clk_on_d;
    end
  end

  // Enables only; the analog path itself stays in the pad ring
  // analog switch enables; pin C0 feeds both ADC and comparator
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      adc_a_channel0      <= 1'b0;
      comparator_a_input3 <= 1'b0;
      adc_a_channel1      <= 1'b0;
      adc_a_channel2      <= 1'b0;
    end else begin
      adc_a_channel0      <= c0_analog;
      comparator_a_input3 <= c0_analog;
      adc_a_channel1      <= c1_analog;
      adc_a_channel2      <= c2_analog;
    end
  end

endmodule

// [logic/pin_mux_pkg.sv]
// Purpose: Shared constants for the Port B/C pin-function multiplexer.
// Assumes: One pin-selection field per pin, driven by the system integration unit.
// Notes:   Code zero of every field is the general-purpose function.
package pin_mux_pkg;

  // Pin positions within the pad vectors
  localparam int NUM_PINS = 8;
  localparam int PIN_B5   = 0;
  localparam int PIN_B6   = 1;
  localparam int PIN_B7   = 2;
  localparam int PIN_B10  = 3;
  localparam int PIN_B11  = 4;
  localparam int PIN_C0   = 5;
  localparam int PIN_C1   = 6;
  localparam int PIN_C2   = 7;

  // Selection field width
  localparam int SEL_W = 2;

  // Common code: general-purpose I/O
  localparam logic [1:0] SEL_GPIO = 2'h0;

  // Port B pin 5 alternates
  localparam logic [1:0] SEL_B5_TIMER = 2'h1;
  localparam logic [1:0] SEL_B5_FAULT = 2'h2;
  localparam logic [1:0] SEL_B5_EXTERNAL_CLOCK_INPUT = 2'h3;

  // Port B pin 6 alternates
  localparam logic [1:0] SEL_B6_RECEIVE = 2'h1;
  localparam logic [1:0] SEL_B6_SDA     = 2'h2;
  localparam logic [1:0] SEL_B6_EXTERNAL_CLOCK_INPUT   = 2'h3;

  // Port B pin 7 alternates
  localparam logic [1:0] SEL_B7_TRANSMIT = 2'h1;
  localparam logic [1:0] SEL_B7_SCL      = 2'h2;

  // Comparator output pins and analog Port C pins
  localparam logic [1:0] SEL_CMP_OUT = 2'h1;
  localparam logic [1:0] SEL_ANALOG  = 2'h1;

  // Idle levels presented to peripherals whose pin is not selected
  localparam logic IDLE_TIMER_IN = 1'h0;
  localparam logic IDLE_FAULT    = 1'h0;
  localparam logic IDLE_RECEIVE  = 1'h1;
  localparam logic IDLE_I2C      = 1'h1;
  localparam logic IDLE_EXTERNAL_CLOCK_INPUT    = 1'h0;

  // Clock-mode bit value that selects the external clock
  localparam logic OSC_CLOCK_SOURCE_SELECT_EXTERNAL = 1'h1;

  // Reset values
  localparam logic [7:0] RST_PIN_OUT = 8'h00;
  localparam logic [7:0] RST_PIN_OE  = 8'h00;
  localparam logic [1:0] RST_SEL     = 2'h0;

endpackage

// [logic/pin_sync.sv]
// Purpose: Two-flop synchroniser bank for the pad inputs.
// Assumes: Pad levels are asynchronous to mclk.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// [test/pin_mux_properties.sv]
// Purpose: Port-level properties of the pin function mux.
// Assumes: Registered outputs; pads pass a two-flop synchroniser.
// Notes:   live_q holds checks off after reset; the fault-path check waits until the synchroniser is flushed.
`timescale 1ns/100ps
module pin_mux_properties
  import pin_mux_pkg::*;
(
  // Clock, reset and pads
  input wire logic                mclk, nrst,
  input wire logic [NUM_PINS-1:0] pad_in, pad_out, pad_oe, gpio_dir_out,
  // Selections
  input wire logic [SEL_W-1:0]    sel_b5, sel_b6, sel_b7, sel_b10, sel_b11, sel_c0,
  // Peripheral side
  input wire logic                osc_clock_source_select, serial0_single_wire,
  input wire logic                serial0_tx_drive, comparator_a_out, comparator_b_out,
  input wire logic                pwm_fault_in_3, external_clock_active,
  input wire logic                adc_a_channel0, comparator_a_input3
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [2:0] live_q;
  // Reset history; a pad path needs three clean edges
  always_ff @(posedge mclk) live_q <= {live_q[1:0], nrst};
  sequence s_fault_sel;
    &live_q[2:0] ##0 $past(sel_b5) == SEL_B5_FAULT;
  endsequence
  a_reset_idle: assert property (disable iff (1'h0)
    !nrst |=> pad_oe == 8'h00 && !adc_a_channel0 && !pwm_fault_in_3) else $error("reset not idle");
  a_gpio_dir: assert property (live_q[0] && $past(sel_b10) == SEL_GPIO
    |-> pad_oe[3] == $past(gpio_dir_out[3])) else $error("gpio direction wrong");
  a_cmp_a_pin: assert property (live_q[0] && $past(sel_b10) == SEL_CMP_OUT
    |-> pad_oe[3] && pad_out[3] == $past(comparator_a_out)) else $error("cmp a pin wrong");
  a_cmp_b_pin: assert property (live_q[0] && $past(sel_b11) == SEL_CMP_OUT
    |-> pad_oe[4] && pad_out[4] == $past(comparator_b_out)) else $error("cmp b pin wrong");
  a_fault_path: assert property (s_fault_sel
    |-> pwm_fault_in_3 == $past(pad_in[0], 3)) else $error("fault path wrong");
  a_fault_idle: assert property (live_q[0] && $past(sel_b5) != SEL_B5_FAULT
    |-> !pwm_fault_in_3) else $error("fault not idle");
  a_clk_mode: assert property (live_q[0] && $past(sel_b6) == SEL_B6_EXTERNAL_CLOCK_INPUT
    && $past(sel_b5) != SEL_B5_EXTERNAL_CLOCK_INPUT
    |-> external_clock_active == ($past(osc_clock_source_select) == OSC_CLOCK_SOURCE_SELECT_EXTERNAL))
    else $error("clock mode wrong");
  a_analog_c0: assert property (live_q[0] |-> comparator_a_input3 == adc_a_channel0
    && adc_a_channel0 == ($past(sel_c0) == SEL_ANALOG)) else $error("analog c0 wrong");
  a_single_wire: assert property (live_q[0] && $past(sel_b7) == SEL_B7_TRANSMIT
    |-> pad_oe[2] == ($past(serial0_tx_drive) || !$past(serial0_single_wire)))
    else $error("transmit enable wrong");
  a_sda_low_only: assert property (live_q[0] && $past(sel_b6) == SEL_B6_SDA
    |-> !pad_out[1]) else $error("sda driven high");
endmodule
bind pin_function_mux pin_mux_properties props_u (.mclk, .nrst, .pad_in, .pad_out, .pad_oe,
  .gpio_dir_out, .sel_b5, .sel_b6, .sel_b7, .sel_b10, .sel_b11, .sel_c0,
  .osc_clock_source_select, .serial0_single_wire, .serial0_tx_drive, .comparator_a_out,
  .comparator_b_out, .pwm_fault_in_3, .external_clock_active, .adc_a_channel0,
  .comparator_a_input3);

// [test/pad_far_side.sv]
// Purpose: Board side of the pads, resolving each wire level.
// Assumes: Port B pins have pull-ups, Port C pins float.
// Notes:   A floating pin toggles so a stale read is caught.
`timescale 1ns/100ps
module pad_far_side
  import pin_mux_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic [NUM_PINS-1:0] pad_out, pad_oe, ext_val, ext_en,
  output logic      [NUM_PINS-1:0] pad_in
);
  logic flt_q = 1'h0;
  // Float pattern changes every cycle
  always_ff @(posedge mclk) flt_q <= !flt_q;
  wire [NUM_PINS-1:0] idle = {{3{flt_q}}, 5'h1F};
  // Wired-and of both parties; undriven pins show idle
  assign pad_in = (pad_oe & pad_out | ~pad_oe) & (ext_en & ext_val | ~ext_en & (idle | pad_oe));
endmodule

// [test/pin_function_mux_tb_top.sv]
// Purpose: Self-checking bench for the pin function mux.
// Assumes: Inputs change on the falling edge of mclk.
// Notes:   Results are due one edge later, three or four on pad paths.
`timescale 1ns/100ps
module pin_function_mux_tb_top;
  import pin_mux_pkg::*;
  typedef struct {int due; int b; logic v;} note_t;
  logic mclk = 1'h0, nrst, osc_clock_source_select, timer_a_channel1_out, timer_a_channel1_oe;
  logic serial0_transmit, serial0_single_wire, serial0_tx_drive, i2c_sda_drive_low;
  logic i2c_scl_drive_low, comparator_a_out, comparator_b_out;
  logic [SEL_W-1:0] sel_b5, sel_b6, sel_b7, sel_b10, sel_b11, sel_c0, sel_c1, sel_c2;
  logic [NUM_PINS-1:0] gpio_data_out, gpio_dir_out, ext_val, ext_en;
  logic [31:0] lfsr = 32'h9A36;
  wire [NUM_PINS-1:0] pad_in, pad_out, pad_oe, gpio_data_in;
  wire timer_a_channel1_in, pwm_fault_in_3, serial0_receive, external_clock_active;
  wire adc_a_channel0, comparator_a_input3, adc_a_channel1, adc_a_channel2;
  wire i2c_sda_in, i2c_scl_in, external_clock_input;
  // Bit map: pad_out 0-7, pad_oe 8-15, gpio_data_in 16-23, then single signals
  wire [34:0] obs = {external_clock_input, i2c_scl_in, i2c_sda_in, timer_a_channel1_in,
    adc_a_channel2, adc_a_channel1, comparator_a_input3, adc_a_channel0, external_clock_active,
    serial0_receive, pwm_fault_in_3, gpio_data_in, pad_oe, pad_out};
  note_t q[$];
  int cyc = 0, bad_count = 0, n_compared = 0;
  pin_function_mux dut_u (.mclk, .nrst, .pad_in, .pad_out, .pad_oe, .sel_b5, .sel_b6, .sel_b7,
    .sel_b10, .sel_b11, .sel_c0, .sel_c1, .sel_c2, .osc_clock_source_select, .gpio_data_out,
    .gpio_dir_out, .gpio_data_in, .timer_a_channel1_out, .timer_a_channel1_oe,
    .timer_a_channel1_in, .pwm_fault_in_3, .serial0_transmit, .serial0_single_wire,
    .serial0_tx_drive, .serial0_receive, .i2c_sda_drive_low, .i2c_scl_drive_low,
    .i2c_sda_in, .i2c_scl_in, .comparator_a_out, .comparator_b_out,
    .external_clock_input, .external_clock_active, .adc_a_channel0, .comparator_a_input3,
    .adc_a_channel1, .adc_a_channel2);
  pad_far_side pads_u (.mclk, .pad_out, .pad_oe, .ext_val, .ext_en, .pad_in);
  function automatic logic [31:0] rnd(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic note(int b, logic v, int lat);
    q.push_back('{cyc + lat, b, v});
  endtask
  task automatic check(logic seen, logic want);
    n_compared++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: seen %b want %b", $time, seen, want);
    end
  endtask
  task automatic hold(int n, string s);
    repeat (n) @(negedge mclk);
    if (s != "") $display("test %s finished", s);
  endtask
  task automatic complete_run();
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Clock; outputs are read 5 ns after each rising edge so they have settled
  always #25 mclk = !mclk;
  always @(posedge mclk) begin
    #5;
    cyc++;
    while (q.size() > 0 && q[0].due <= cyc) begin
      check(obs[q[0].b], q[0].v);
      void'(q.pop_front());
    end
  end
  // Watchdog, far beyond the about 116 cycles the tests take
  initial begin
    #(3000 * 50);
    bad_count++;
    complete_run();
  end
  initial begin
    {nrst, osc_clock_source_select, timer_a_channel1_out, timer_a_channel1_oe} = '0;
    {serial0_transmit, serial0_single_wire, serial0_tx_drive, i2c_sda_drive_low} = '0;
    {i2c_scl_drive_low, comparator_a_out, comparator_b_out, gpio_data_out} = '0;
    {sel_b5, sel_b6, sel_b7, sel_b10, sel_b11, sel_c0, sel_c1, sel_c2} = '0;
    {gpio_dir_out, ext_val, ext_en} = '0;
    hold(10, "");
    nrst = 1'h1;
    for (int i = 8; i < 17; i++) note(i == 16 ? 27 : i, 1'h0, 1);
    hold(1, "reset");
    // Random GPIO traffic; unselected I2C and timer drives must be ignored
    for (int k = 0; k < 8; k++) begin
      repeat (8) lfsr = rnd(lfsr);
      {i2c_sda_drive_low, i2c_scl_drive_low, timer_a_channel1_oe} = lfsr[26:24];
      {gpio_dir_out, gpio_data_out, ext_val} = lfsr[23:0];
      ext_en = ~gpio_dir_out;
      for (int i = 0; i < 8; i++) begin
        note(8 + i, gpio_dir_out[i], 4);
        note(16 + i, gpio_dir_out[i] ? gpio_data_out[i] : ext_val[i], 4);
      end
      hold(4, k == 7 ? "gpio" : "");
    end
    // Comparator outputs, all four input pairs
    ext_en = '0;
    {sel_b10, sel_b11} = {SEL_CMP_OUT, SEL_CMP_OUT};
    for (int i = 0; i < 4; i++) begin
      {comparator_a_out, comparator_b_out} = i[1:0];
      note(3, i[1], 1);
      note(4, i[0], 1);
      note(12, 1'h1, 1);
      hold(1, i == 3 ? "comparator" : "");
    end
    // Off-chip fault on B5, then timer channel on the same pin
    sel_b5 = SEL_B5_FAULT;
    ext_en[0] = 1'h1;
    for (int i = 0; i < 2; i++) begin
      ext_val[0] = i[0];
      note(24, i[0], 3);
      note(8, 1'h0, 3);
      hold(3, "");
    end
    sel_b5 = SEL_B5_TIMER;
    note(24, 1'h0, 1);
    for (int i = 0; i < 4; i++) begin
      {timer_a_channel1_oe, timer_a_channel1_out} = i[1:0];
      {ext_en[0], ext_val[0]} = {!i[1], !i[0]};
      note(8, i[1], 4);
      note(31, i[1] ? i[0] : !i[0], 4);
      note(0, i[0], 1);
      hold(4, i == 3 ? "fault and timer" : "");
    end
    // B6 clock input also needs the mode bit
    {sel_b5, sel_b6} = {SEL_GPIO, SEL_B6_EXTERNAL_CLOCK_INPUT};
    for (int i = 0; i < 2; i++) begin
      osc_clock_source_select = i[0];
      note(26, i[0] == OSC_CLOCK_SOURCE_SELECT_EXTERNAL, 1);
      hold(1, i == 1 ? "clock input" : "");
    end
    // Analog pins: C0 feeds both, C1 stays digital
    {sel_c0, sel_c2} = {SEL_ANALOG, SEL_ANALOG};
    note(27, 1'h1, 1);
    note(28, 1'h1, 1);
    note(29, 1'h0, 1);
    note(30, 1'h1, 1);
    note(13, 1'h0, 1);
    hold(1, "analog");
    // Transmit pin: output only, then bidirectional in single-wire mode
    sel_b7 = SEL_B7_TRANSMIT;
    for (int i = 0; i < 4; i++) begin
      {serial0_single_wire, serial0_tx_drive, serial0_transmit} = {i[1:0], i[0]};
      {ext_en[2], ext_val[2]} = {i[1] && !i[0], 1'h0};
      note(10, !i[1] || i[0], 4);
      if (!i[1] || i[0]) note(2, i[0], 4);
      if (i == 2) note(25, 1'h0, 4);
      hold(4, i == 3 ? "single wire" : "");
    end
    // I2C lines on B6/B7, released to the board pull-ups or pulled low
    {sel_b6, sel_b7, serial0_single_wire} = {SEL_B6_SDA, SEL_B7_SCL, 1'h0};
    for (int i = 0; i < 4; i++) begin
      {i2c_sda_drive_low, i2c_scl_drive_low} = i[1:0];
      note(9, i[1], 1);
      note(10, i[0], 1);
      note(1, 1'h0, 1);
      note(2, 1'h0, 1);
      note(25, 1'h1, 1);
      note(32, !i[1], 4);
      note(33, !i[0], 4);
      hold(4, i == 3 ? "i2c" : "");
    end
    // B6 receive from the board, B5 clock input needs no mode bit
    {sel_b5, sel_b6} = {SEL_B5_EXTERNAL_CLOCK_INPUT, SEL_B6_RECEIVE};
    ext_en[1:0] = 2'h3;
    for (int i = 0; i < 4; i++) begin
      ext_val[1:0] = i[1:0];
      note(8, 1'h0, 1);
      note(26, 1'h1, 1);
      note(24, 1'h0, 1);
      note(32, 1'h1, 1);
      note(25, i[1], 3);
      note(34, i[0], 3);
      hold(3, i == 3 ? "receive and clock" : "");
    end
    complete_run();
  end
endmodule
